/* periodic_timer_pulse_capture.sv */
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
// Periodic 10-bit timer: single pulse, capture, PWM and compare modes.
// Assumes a plain register port and asynchronous trigger and capture pins.
module periodic_timer_pulse_capture
  import ptimer_pkg::*;
#(
  parameter int CW = CNT_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire busReq_s busReq,
  output logic [7:0] rdData,
  input wire logic externalTriggerPin,
  input wire logic capturePin,
  output logic timerOutputPin,
  output logic cmpAMatch,
  output logic cmpPMatch,
  output logic timerIrq
);

  typedef struct packed {
    logic runEnable;
    logic runPrev;
    logic [1:0] timerMode;
    logic [1:0] outputAction;
    logic outputInitialLevel;
    logic outputPolarity;
    logic captureSourceSelect;
    logic counterClearSelect;
    logic [CW-1:0] counter;
    logic [CW-1:0] comparatorAValue;
    logic [CW-1:0] comparatorPValue;
    logic outLevel;
    logic [7:0] rdData;
    logic matchA;
    logic matchP;
    logic irq;
  } st_s;

  st_s st_ff;
  st_s nxt_st;

  logic [1:0] pinRise;
  logic [1:0] pinFall;

  // Synchronise trigger (bit 1) and capture (bit 0) pins
  pin_sync #(
    .W(2)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .pinIn({externalTriggerPin, capturePin}),
    .level(),
    .rise(pinRise),
    .fall(pinFall)
  );

  // Active capture edge for the chosen edge code
  function automatic logic edgeHit(input logic [1:0] code, input logic r, input logic f);
    logic hit;
    hit = 1'b0;
    case (code)
      EDGE_RISE: hit = r;
      EDGE_FALL: hit = f;
      EDGE_BOTH: hit = r | f;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Merge a byte into the low or high part of a 10-bit value
  function automatic logic [CW-1:0] putByte(input logic [CW-1:0] v, input logic hi, input logic [7:0] d);
    logic [CW-1:0] r;
    r = v;
    if (hi) begin
      r[CW-1:8] = d[CW-9:0];
    end else begin
      r[7:0] = d;
    end
    return r;
  endfunction

  // Read a byte of a 10-bit value, upper bits zero
  function automatic logic [7:0] getByte(input logic [CW-1:0] v, input logic hi);
    logic [7:0] r;
    r = 8'h00;
    if (hi) begin
      r[CW-9:0] = v[CW-1:8];
    end else begin
      r = v[7:0];
    end
    return r;
  endfunction

  logic inPulse;
  logic inCap;
  logic inPwm;
  logic capSel;
  logic capRise;
  logic capFall;
  logic runRise;
  logic atA;
  logic atP;
  logic capHit;
  logic [CW-1:0] counterMax;

  assign inPulse = (st_ff.timerMode == MODE_PWM) && (st_ff.outputAction == ACT_PULSE);
  assign inCap = st_ff.timerMode == MODE_CAP;
  assign inPwm = (st_ff.timerMode == MODE_PWM) && !inPulse;
  assign counterMax = '1;
  // Source select: 0 capture pin, 1 trigger pin; acts even if shared pin drives
  assign capSel = st_ff.captureSourceSelect;
  assign capRise = capSel ? pinRise[1] : pinRise[0];
  assign capFall = capSel ? pinFall[1] : pinFall[0];
  assign capHit = inCap && st_ff.runEnable && edgeHit(st_ff.outputAction, capRise, capFall);
  assign runRise = st_ff.runEnable && !st_ff.runPrev;
  assign atA = st_ff.runEnable && !runRise && (st_ff.counter == st_ff.comparatorAValue);
  assign atP = st_ff.runEnable && !runRise && (st_ff.counter == st_ff.comparatorPValue);

  // Next state of the whole timer
  always_comb begin
    logic clearCnt;
    logic pulseLevel;
    logic fixedLevel;
    clearCnt = 1'b0;
    pulseLevel = 1'b0;
    fixedLevel = 1'b0;
    nxt_st = st_ff;
    nxt_st.runPrev = st_ff.runEnable;
    nxt_st.matchA = 1'b0;
    nxt_st.matchP = 1'b0;
    nxt_st.irq = 1'b0;
    nxt_st.rdData = 8'h00;

    // Counter: restart at zero on run rise, stop while disabled
    if (runRise) begin
      nxt_st.counter = '0;
    end else if (st_ff.runEnable) begin
      if (inPulse) begin
        nxt_st.counter = st_ff.counter + 1'b1;
      end else if (inCap) begin
        // P match wraps; P zero means full count
        if (st_ff.comparatorPValue == '0) begin
          nxt_st.counter = st_ff.counter + 1'b1;
        end else if (atP) begin
          clearCnt = 1'b1;
          nxt_st.counter = '0;
        end else begin
          nxt_st.counter = st_ff.counter + 1'b1;
        end
      end else if (inPwm) begin
        // Period always from P, clear-select ignored
        if (atP || (st_ff.comparatorPValue == '0 && st_ff.counter == counterMax)) begin
          nxt_st.counter = '0;
          clearCnt = 1'b1;
        end else begin
          nxt_st.counter = st_ff.counter + 1'b1;
        end
      end else begin
        // Compare and timer modes
        if (st_ff.counterClearSelect ? atA : (atP || (st_ff.comparatorPValue == '0 && st_ff.counter == counterMax))) begin
          nxt_st.counter = '0;
          clearCnt = 1'b1;
        end else begin
          nxt_st.counter = st_ff.counter + 1'b1;
        end
      end
    end

    // Match flags and interrupt request
    if (inPulse) begin
      nxt_st.matchA = atA;
      nxt_st.irq = atA;
    end else if (inCap) begin
      nxt_st.matchA = capHit;
      nxt_st.matchP = atP && clearCnt;
      nxt_st.irq = capHit || (atP && clearCnt);
    end else begin
      nxt_st.matchA = atA;
      nxt_st.matchP = atP && !(st_ff.counterClearSelect && !inPwm);
      nxt_st.irq = nxt_st.matchA || nxt_st.matchP;
    end

    // Capture copies counter into comparator A
    if (capHit) begin
      nxt_st.comparatorAValue = st_ff.counter;
    end

    // Output level before polarity
    if (inPulse) begin
      pulseLevel = ~st_ff.outputInitialLevel;
      nxt_st.outLevel = st_ff.runEnable ? pulseLevel : st_ff.outputInitialLevel;
    end else if (inPwm) begin
      fixedLevel = (st_ff.counter < st_ff.comparatorAValue) ? st_ff.outputInitialLevel : ~st_ff.outputInitialLevel;
      case (st_ff.outputAction)
        ACT_LOW: nxt_st.outLevel = 1'b0;
        ACT_HIGH: nxt_st.outLevel = 1'b1;
        default: nxt_st.outLevel = st_ff.runEnable ? fixedLevel : st_ff.outputInitialLevel;
      endcase
    end else if (inCap) begin
      nxt_st.outLevel = 1'b0;
    end else if (st_ff.timerMode == MODE_CMP) begin
      if (runRise) begin
        nxt_st.outLevel = st_ff.outputInitialLevel;
      end else if (atA) begin
        case (st_ff.outputAction)
          ACT_HIGH: nxt_st.outLevel = 1'b0;
          ACT_PWM: nxt_st.outLevel = 1'b1;
          ACT_PULSE: nxt_st.outLevel = ~st_ff.outLevel;
          default: nxt_st.outLevel = st_ff.outLevel;
        endcase
      end
    end

    // Run enable: trigger edge sets, A match clears in single pulse
    if (inPulse && atA) begin
      nxt_st.runEnable = 1'b0;
    end else if (inPulse && !st_ff.runEnable && pinRise[1]) begin
      nxt_st.runEnable = 1'b1;
    end

    // Register writes; bus run-enable writes lose to none but A match
    if (busReq.wr) begin
      if (busReq.addr == OFS_CTRL0) begin
        if (!(inPulse && atA)) begin
          nxt_st.runEnable = busReq.wdata[POS_RUN];
        end
      end else if (busReq.addr == OFS_CTRL1) begin
        nxt_st.timerMode = busReq.wdata[POS_MODE +: 2];
        nxt_st.outputAction = busReq.wdata[POS_ACT +: 2];
        nxt_st.outputInitialLevel = busReq.wdata[POS_INIT];
        nxt_st.outputPolarity = busReq.wdata[POS_POL];
        nxt_st.captureSourceSelect = busReq.wdata[POS_SRC];
        nxt_st.counterClearSelect = busReq.wdata[POS_CLR];
      end else if (busReq.addr == OFS_CMPAL || busReq.addr == OFS_CMPAH) begin
        if (!capHit) begin
          nxt_st.comparatorAValue = putByte(st_ff.comparatorAValue, busReq.addr[0], busReq.wdata);
        end
      end else if (busReq.addr == OFS_CMPPL || busReq.addr == OFS_CMPPH) begin
        nxt_st.comparatorPValue = putByte(st_ff.comparatorPValue, busReq.addr[0], busReq.wdata);
      end
    end

    // Register reads, data valid next cycle
    if (busReq.rd) begin
      if (busReq.addr == OFS_CTRL0) begin
        nxt_st.rdData[POS_RUN] = st_ff.runEnable;
      end else if (busReq.addr == OFS_CTRL1) begin
        nxt_st.rdData = {st_ff.timerMode, st_ff.outputAction, st_ff.outputInitialLevel,
                         st_ff.outputPolarity, st_ff.captureSourceSelect, st_ff.counterClearSelect};
      end else if (busReq.addr == OFS_CNTL || busReq.addr == OFS_CNTH) begin
        nxt_st.rdData = getByte(st_ff.counter, busReq.addr[0]);
      end else if (busReq.addr == OFS_CMPAL || busReq.addr == OFS_CMPAH) begin
        nxt_st.rdData = getByte(st_ff.comparatorAValue, busReq.addr[0]);
      end else begin
        nxt_st.rdData = getByte(st_ff.comparatorPValue, busReq.addr[0]);
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.timerMode <= RST_CTRL1[POS_MODE +: 2];
      st_ff.outputAction <= RST_CTRL1[POS_ACT +: 2];
      st_ff.runEnable <= RST_CTRL0[POS_RUN];
      st_ff.comparatorAValue <= RST_CMP;
      st_ff.comparatorPValue <= RST_CMP;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Polarity inverts except in timer mode and capture mode
  assign timerOutputPin = st_ff.outLevel ^ (st_ff.outputPolarity && !inCap &&
                          st_ff.timerMode != MODE_TMR);
  assign rdData = st_ff.rdData;
  assign cmpAMatch = st_ff.matchA;
  assign cmpPMatch = st_ff.matchP;
  assign timerIrq = st_ff.irq;
endmodule

/* ptimer_pkg.sv */
// Constants, register map and carrier types of the periodic timer block.
// Assumes a plain register port with read data one cycle after the strobe.
package ptimer_pkg;

  localparam int CNT_W = 10;
  localparam int ADDR_W = 3;

  // Register offsets
  localparam logic [2:0] OFS_CTRL0 = 3'h0;
  localparam logic [2:0] OFS_CTRL1 = 3'h1;
  localparam logic [2:0] OFS_CNTL = 3'h2;
  localparam logic [2:0] OFS_CNTH = 3'h3;
  localparam logic [2:0] OFS_CMPAL = 3'h4;
  localparam logic [2:0] OFS_CMPAH = 3'h5;
  localparam logic [2:0] OFS_CMPPL = 3'h6;
  localparam logic [2:0] OFS_CMPPH = 3'h7;

  // Control zero field positions
  localparam int POS_RUN = 3;
  // Control one field positions
  localparam int POS_MODE = 6;
  localparam int POS_ACT = 4;
  localparam int POS_INIT = 3;
  localparam int POS_POL = 2;
  localparam int POS_SRC = 1;
  localparam int POS_CLR = 0;

  // Reset values
  localparam logic [7:0] RST_CTRL0 = 8'h00;
  localparam logic [7:0] RST_CTRL1 = 8'h00;
  localparam logic [9:0] RST_CMP = 10'h000;

  typedef enum logic [1:0] {
    MODE_CMP = 2'b00,
    MODE_CAP = 2'b01,
    MODE_PWM = 2'b10,
    MODE_TMR = 2'b11
  } mode_e;

  typedef enum logic [1:0] {
    ACT_LOW = 2'b00,
    ACT_HIGH = 2'b01,
    ACT_PWM = 2'b10,
    ACT_PULSE = 2'b11
  } act_e;

  // Capture edge codes
  localparam logic [1:0] EDGE_RISE = 2'b00;
  localparam logic [1:0] EDGE_FALL = 2'b01;
  localparam logic [1:0] EDGE_BOTH = 2'b10;

  // Register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } busReq_s;

  // Pin inputs after synchronising
  typedef struct packed {
    logic trig;
    logic cap;
  } pins_s;

endpackage

/* pin_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser for pin inputs with an edge detector after it.
// Assumes asynchronous pins and one clock.
module pin_sync #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } st_s;

  st_s st_ff;
  st_s nxt_st;

  // Shift chain; only s2 and s3 feed logic
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = pinIn;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level = st_ff.s2;
  assign rise = st_ff.s2 & ~st_ff.s3;
  assign fall = ~st_ff.s2 & st_ff.s3;
endmodule

/* ptimer_monitor.sv */
`timescale 1ns/1ps
// Port checker for the periodic timer: output timing against bus and pins.
// Assumes it is bound to the timer top and shadows mode and P writes itself.
module ptimer_monitor
  import ptimer_pkg::*;
#(
  parameter int CW = CNT_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire busReq_s busReq,
  input wire logic [7:0] rdData,
  input wire logic externalTriggerPin,
  input wire logic capturePin,
  input wire logic timerOutputPin,
  input wire logic cmpAMatch,
  input wire logic cmpPMatch,
  input wire logic timerIrq
);
  logic [7:0] ctrlSh;
  logic [CW-1:0] pSh;
  logic capMode;
  logic spMode;
  logic restLvl;
  // Shadow of the mode byte and P value, taken on the write edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrlSh <= 8'h00;
      pSh <= '0;
    end else if (busReq.wr) begin
      if (busReq.addr == OFS_CTRL1) ctrlSh <= busReq.wdata;
      if (busReq.addr == OFS_CMPPL) pSh[7:0] <= busReq.wdata;
      if (busReq.addr == OFS_CMPPH) pSh[CW-1:8] <= busReq.wdata[CW-9:0];
    end
  end
  // Decoded modes and resting pin level
  assign capMode = ctrlSh[7:6] == 2'b01;
  assign spMode = ctrlSh[7:4] == 4'hB;
  assign restLvl = ctrlSh[3] ^ ctrlSh[2];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  rd_idle_zero_a: assert property (!$past(busReq.rd) |-> rdData == 8'h00)
    else $error("read data outside read slot");
  a_irq_pair_a: assert property (cmpAMatch |-> timerIrq)
    else $error("A event without interrupt");
  p_irq_pair_a: assert property (capMode && cmpPMatch |-> timerIrq)
    else $error("P match without interrupt");
  p_zero_wrap_a: assert property (capMode && pSh == '0 |-> !cmpPMatch)
    else $error("P match with zero P value");
  p_spacing_a: assert property (capMode && cmpPMatch && pSh > 10'h002 |=> !cmpPMatch [*2])
    else $error("P match too soon after clear");
  pulse_end_rest_a: assert property (spMode && cmpAMatch |=> timerOutputPin == restLvl)
    else $error("pulse not ended at A match");
  trig_start_a: assert property (spMode && $rose(externalTriggerPin) && timerOutputPin == restLvl
    |-> ##[1:6] timerOutputPin != restLvl)
    else $error("trigger edge did not start pulse");
  cap_off_none_a: assert property (capMode && ctrlSh[5:4] == 2'b11 |-> !cmpAMatch)
    else $error("capture with edges disabled");
  cap_pin_still_a: assert property (capMode && $past(capMode) && $past(capMode, 2) |-> $stable(timerOutputPin))
    else $error("output moved in capture mode");
endmodule

/* pin_partner.sv */
`timescale 1ns/1ps
// Far-side model: drives the trigger and capture pins.
// Assumes the bench calls drive once per edge at most.
module pin_partner (
  input wire logic clk,
  output logic trig,
  output logic cap
);
  initial begin
    trig = 1'b0;
    cap = 1'b0;
  end
  // Changes one pin just after a rising edge and holds it
  task automatic drive(input logic useTrig, input logic lvl);
    @(posedge clk);
    if (useTrig) trig <= lvl;
    else cap <= lvl;
  endtask
endmodule

/* testbench.sv */
`timescale 1ns/1ps
// Self-checking bench for the periodic timer: bus tasks, note queue, pins.
// Assumes the pin partner and port checker are compiled before it.
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin err_total++; \
  $display("wrong value %s expected %h seen %h", nm, e, s); end end
module testbench;
  import ptimer_pkg::*;
  logic clk, rst, trig, cap, outPin, aHit, pHit, irq, rdPend, pulseWatch, restLvl;
  logic [7:0] rdData, lastRd, v1, w;
  logic [15:0] actCnt;
  logic [16:0] notes[$];
  logic [16:0] note;
  logic [31:0] seed;
  busReq_s busReq;
  int err_total, cmp_count, capN, base, n;

  periodic_timer_pulse_capture #(.CW(CNT_W)) periodic_timer_pulse_capture_i (.clk(clk), .rst(rst),
    .busReq(busReq), .rdData(rdData), .externalTriggerPin(trig), .capturePin(cap),
    .timerOutputPin(outPin), .cmpAMatch(aHit), .cmpPMatch(pHit), .timerIrq(irq));
  pin_partner pin_partner_i (.clk(clk), .trig(trig), .cap(cap));

  // Clock source
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Result watcher: takes the oldest note when read data or a pulse end appears
  always @(posedge clk) begin
    if (rdPend) begin
      note = notes.pop_front();
      lastRd = rdData;
      if (note[16]) `CHK("read data", note[7:0], rdData)
    end
    if (pulseWatch && aHit) begin
      note = notes.pop_front();
      `CHK("pulse width", note[15:0], actCnt)
    end
    if (aHit) capN++;
    actCnt <= (!pulseWatch || aHit) ? 16'h0 : actCnt + 16'(outPin !== restLvl);
    rdPend <= busReq.rd;
  end

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    busReq <= '0;
  endtask

  task automatic rd(input logic [2:0] a, input logic care, input logic [7:0] e);
    notes.push_back({care, 8'h00, e});
    @(posedge clk);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    busReq <= '0;
    @(posedge clk);
    #1;
  endtask

  task automatic wait_hit(input logic useP);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while ((useP ? pHit : aHit) !== 1'b1 && n < 1100);
    if (n >= 1100) begin
      err_total++;
      $display("wrong value match wait expected pulse seen none");
      finish_test();
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    busReq = '0;
    rst = 1'b1;
    seed = 32'h3827;
    rdPend = 1'b0;
    pulseWatch = 1'b0;
    restLvl = 1'b0;
    actCnt = 16'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) rd(3'(a), 1'b1, 8'h00);
    $display("test reset values done");
    wr(OFS_CTRL1, 8'h40);
    wr(OFS_CTRL0, 8'h08);
    repeat (9) @(posedge clk);
    rd(OFS_CNTL, 1'b1, 8'h09);
    rd(OFS_CNTH, 1'b1, 8'h00);
    for (int code = 0; code < 4; code++) begin
      for (int src = 0; src < 2; src++) begin
        wr(OFS_CTRL1, {2'b01, 2'(code), 2'b00, 1'(src), 1'b0});
        base = capN;
        pin_partner_i.drive(1'(src), 1'b1);
        repeat (8) @(posedge clk);
        rd(OFS_CMPAL, 1'b0, 8'h00);
        v1 = lastRd;
        repeat (8) @(posedge clk);
        pin_partner_i.drive(1'(src), 1'b0);
        repeat (10) @(posedge clk);
        pin_partner_i.drive(1'(!src), 1'b1);
        repeat (6) @(posedge clk);
        pin_partner_i.drive(1'(!src), 1'b0);
        repeat (8) @(posedge clk);
        rd(OFS_CMPAL, 1'b0, 8'h00);
        `CHK("capture count", (code == 3) ? 0 : (code == 2) ? 2 : 1, capN - base)
        if (code == 2) `CHK("capture gap", 8'd20, 8'(lastRd - v1))
      end
    end
    $display("test capture edges done");
    wr(OFS_CMPPL, 8'd20);
    wait_hit(1'b1);
    wait_hit(1'b1);
    `CHK("P period", 21, n)
    $display("test capture period done");
    wr(OFS_CTRL0, 8'h00);
    // Captures left high bits in A; clear them so the low byte sets the width
    wr(OFS_CMPAH, 8'h00);
    for (int k = 0; k < 4; k++) begin
      w = 8'd5 + 8'(rnd() % 30);
      wr(OFS_CMPAL, w);
      wr(OFS_CTRL1, {4'hB, 1'(k), 1'(k >> 1), 2'b00});
      restLvl = 1'(k) ^ 1'(k >> 1);
      repeat (2) @(posedge clk);
      #1;
      `CHK("rest level", restLvl, outPin)
      pulseWatch = 1'b1;
      notes.push_back({1'b1, 16'(w) + 16'h1});
      if (k[0]) pin_partner_i.drive(1'b1, 1'b1);
      else wr(OFS_CTRL0, 8'h08);
      wait_hit(1'b0);
      // Let the watcher take the width note before closing the window
      @(posedge clk);
      #1;
      pulseWatch = 1'b0;
      pin_partner_i.drive(1'b1, 1'b0);
    end
    $display("test single pulse done");
    // Forced pin levels in PWM mode; period keeps running from P
    for (int act = 0; act < 2; act++) begin
      wr(OFS_CTRL1, {2'b10, 2'(act), 4'h0});
      wr(OFS_CTRL0, 8'h08);
      wait_hit(1'b1);
      wait_hit(1'b1);
      `CHK("PWM period", 21, n)
      `CHK("forced level", 1'(act), outPin)
      wr(OFS_CTRL0, 8'h00);
    end
    $display("test pwm forced done");
    finish_test();
  end
endmodule

bind periodic_timer_pulse_capture ptimer_monitor #(.CW(CW)) ptimer_monitor_i (.clk(clk), .rst(rst),
  .busReq(busReq), .rdData(rdData), .externalTriggerPin(externalTriggerPin), .capturePin(capturePin),
  .timerOutputPin(timerOutputPin), .cmpAMatch(cmpAMatch), .cmpPMatch(cmpPMatch), .timerIrq(timerIrq));
